// [hdl/cra_accel.sv]
// APB register block and serial engine of the CRC accelerator.
`timescale 1ns/1ns
`default_nettype none
`include "cra_defs.svh"

module cra_accel #(
  parameter logic [3:0] REVISION = 4'h3, // Arbitrary value.
  parameter int         DEPTH    = `CRA_FIFO_DEPTH
) (
  // Clock, reset and freeze
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  // Power management
  input  wire logic        hib_exit,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata
);

  // ****************************************
  // Input word buffer
  // ****************************************
  cra_stream_if #(.W(`CRA_WORD_W)) fill_if ();
  cra_stream_if #(.W(`CRA_WORD_W)) drain_if ();

  cra_fifo #(
    .W     (`CRA_WORD_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk   (clk),
    .reset (reset),
    .ce    (ce),
    .fill  (fill_if),
    .drain (drain_if)
  );

  // ****************************************
  // Mirroring of a written word
  // ****************************************
  function automatic logic [31:0] cra_mirror(
    input logic [31:0] din,
    input logic        swap,
    input logic        bytes,
    input logic        bits
  );
    logic [31:0] w;
    logic [31:0] r;
    w = din;
    r = din;
    if (swap)
    begin
      w = {w[15:0], w[31:16]};
    end
    if (bytes)
    begin
      w = {w[23:16], w[31:24], w[7:0], w[15:8]};
    end
    // Bits are read from a copy, since an in-place reversal would swap each pair twice.
    if (bits)
    begin
      r = w;
      for (int i = 0; i < 32; i++)
      begin
        w[i] = din_bit(r, i);
      end
    end
    return w;
  endfunction

  // Picks the bit at the mirrored position within the same byte.
  function automatic logic din_bit(input logic [31:0] w, input int i);
    int base;
    base = i - (i % 8);
    return w[base + 7 - (i % 8)];
  endfunction

  // ****************************************
  // State
  // ****************************************
  cra_pkg::cra_regs_t s_ff;
  cra_pkg::cra_regs_t nxt_s;

  logic        access;
  logic        commit;
  logic        hit_ctrl;
  logic        hit_input;
  logic        hit_result;
  logic        hit_divisor;
  logic        mapped;
  logic        idle;
  logic        may_answer;
  logic        fb;
  logic        in_bit;
  logic [31:0] ctrl_rd;
  logic [31:0] word_in;

  assign hit_ctrl    = (paddr == `CRA_ADDR_CTRL);
  assign hit_input   = (paddr == `CRA_ADDR_INPUT);
  assign hit_result  = (paddr == `CRA_ADDR_RESULT);
  assign hit_divisor = (paddr == `CRA_ADDR_DIVISOR);
  assign mapped      = hit_ctrl | hit_input | hit_result | hit_divisor;
  assign access      = psel && penable && !s_ff.pready;
  assign commit      = psel && penable && s_ff.pready;
  assign idle        = (s_ff.state == cra_pkg::CRA_IDLE) && !drain_if.valid;

  // A word write while enabled waits only for buffer room; anything else waits for the
  // engine to drain, so no access can observe a half-folded result.
  always_comb
  begin
    if (pwrite && hit_input && s_ff.enable)
    begin
      may_answer = fill_if.ready;
    end
    else
    begin
      may_answer = idle;
    end
  end

  // Input word writes while disabled are dropped without an error.
  assign fill_if.valid = commit && pwrite && hit_input && s_ff.enable;
  assign fill_if.data  = pwdata;

  always_comb
  begin
    ctrl_rd = `CRA_ZERO_RST;
    ctrl_rd[`CRA_REV_MSB:`CRA_REV_LSB] = REVISION;
    ctrl_rd[`CRA_BIT_SWAP]  = s_ff.halfword_swap;
    ctrl_rd[`CRA_BIT_BYTE]  = s_ff.byte_mirror;
    ctrl_rd[`CRA_BIT_BITS]  = s_ff.bit_mirror;
    ctrl_rd[`CRA_BIT_ORDER] = s_ff.reflected_order;
    ctrl_rd[`CRA_BIT_EN]    = s_ff.enable;
  end

  assign word_in = cra_mirror(drain_if.data, s_ff.halfword_swap, s_ff.byte_mirror,
                              s_ff.bit_mirror);
  assign drain_if.ready = (s_ff.state == cra_pkg::CRA_IDLE);
  assign in_bit = s_ff.mirrored_input[31];
  assign fb     = s_ff.reflected_order ? (s_ff.result[0] ^ in_bit)
                                       : (s_ff.result[31] ^ in_bit);

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    nxt_s = s_ff;

    // Bus answer: ready for exactly one cycle, data and error with it.
    if (access && may_answer)
    begin
      nxt_s.pready  = 1'b1;
      nxt_s.pslverr = !mapped;
      nxt_s.prdata  = `CRA_ZERO_RST;
      if (!pwrite && hit_ctrl)
      begin
        nxt_s.prdata = ctrl_rd;
      end
      if (!pwrite && hit_result)
      begin
        nxt_s.prdata = s_ff.result;
      end
      if (!pwrite && hit_divisor)
      begin
        nxt_s.prdata = s_ff.divisor;
      end
    end
    else
    begin
      nxt_s.pready  = 1'b0;
      nxt_s.pslverr = 1'b0;
    end

    // Register writes take effect at the completing edge.
    if (commit && pwrite && hit_ctrl)
    begin
      nxt_s.halfword_swap   = pwdata[`CRA_BIT_SWAP];
      nxt_s.byte_mirror     = pwdata[`CRA_BIT_BYTE];
      nxt_s.bit_mirror      = pwdata[`CRA_BIT_BITS];
      nxt_s.reflected_order = pwdata[`CRA_BIT_ORDER];
      nxt_s.enable          = pwdata[`CRA_BIT_EN];
    end
    if (commit && pwrite && hit_divisor)
    begin
      nxt_s.divisor = pwdata;
    end

    // Serial engine.
    unique case (s_ff.state)
      cra_pkg::CRA_IDLE:
      begin
        if (drain_if.valid)
        begin
          nxt_s.mirrored_input = word_in;
          nxt_s.bit_cnt        = `CRA_FIRST_BIT;
          nxt_s.state          = cra_pkg::CRA_RUN;
        end
      end
      cra_pkg::CRA_RUN:
      begin
        nxt_s.mirrored_input = {s_ff.mirrored_input[30:0], 1'b0};
        if (s_ff.reflected_order)
        begin
          nxt_s.result = {1'b0, s_ff.result[31:1]} ^ (fb ? s_ff.divisor : '0);
        end
        else
        begin
          nxt_s.result = {s_ff.result[30:0], 1'b0} ^ (fb ? s_ff.divisor : '0);
        end
        nxt_s.bit_cnt = s_ff.bit_cnt - 5'h01;
        if (s_ff.bit_cnt == `CRA_LAST_BIT)
        begin
          nxt_s.state = cra_pkg::CRA_IDLE;
        end
      end
      default:
      begin
        nxt_s.state = cra_pkg::CRA_IDLE;
      end
    endcase

    // A seed write is only answered while the engine is idle.
    if (commit && pwrite && hit_result)
    begin
      nxt_s.result = pwdata;
    end

    // Hibernate exit drops only the enable; the rest is retained.
    if (hib_exit)
    begin
      nxt_s.enable = 1'b0;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s_ff                 <= '0;
      s_ff.divisor         <= `CRA_DIVISOR_RST;
      s_ff.result          <= `CRA_ZERO_RST;
      s_ff.reflected_order <= 1'b0;
      s_ff.enable          <= 1'b0;
      s_ff.state           <= cra_pkg::CRA_IDLE;
    end
    else if (ce)
    begin
      s_ff <= nxt_s;
    end
  end

  assign pready  = s_ff.pready;
  assign pslverr = s_ff.pslverr;
  assign prdata  = s_ff.prdata;

endmodule // cra_accel

`default_nettype wire

// [hdl/cra_defs.svh]
// Register map, field positions, reset values and counts of the CRC accelerator.
`ifndef CRA_DEFS_SVH
`define CRA_DEFS_SVH

// ****************************************
// Register byte addresses
// ****************************************
`define CRA_ADDR_CTRL    32'h4004_0000
`define CRA_ADDR_INPUT   32'h4004_0004
`define CRA_ADDR_RESULT  32'h4004_0008
`define CRA_ADDR_DIVISOR 32'h4004_000c

// ****************************************
// Control register fields
// ****************************************
`define CRA_REV_MSB      31
`define CRA_REV_LSB      28
`define CRA_RSVD_MSB     27
`define CRA_RSVD_LSB     5
`define CRA_BIT_SWAP     4
`define CRA_BIT_BYTE     3
`define CRA_BIT_BITS     2
`define CRA_BIT_ORDER    1
`define CRA_BIT_EN       0

// ****************************************
// Reset values and counts
// ****************************************
`define CRA_DIVISOR_RST  32'h04c1_1db7
`define CRA_ZERO_RST     32'h0000_0000
`define CRA_FIRST_BIT    5'h1f
`define CRA_LAST_BIT     5'h00
`define CRA_FIFO_DEPTH   32
`define CRA_WORD_W       32

`endif

// [hdl/cra_fifo.sv]
// Word FIFO that buffers input words ahead of the serial CRC engine.
`timescale 1ns/1ns
`default_nettype none

module cra_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   reset,
  input  wire logic   ce,
  // Streams
  cra_stream_if.snk   fill,
  cra_stream_if.src   drain
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0]             wr_ptr;
    logic [AW:0]             rd_ptr;
  } cra_fifo_t;

  cra_fifo_t s_ff;
  cra_fifo_t nxt_s;
  logic      full;
  logic      empty;

  // Extra pointer bit tells a full FIFO from an empty one.
  assign empty = (s_ff.wr_ptr == s_ff.rd_ptr);
  assign full  = (s_ff.wr_ptr[AW] != s_ff.rd_ptr[AW]) &&
                 (s_ff.wr_ptr[AW-1:0] == s_ff.rd_ptr[AW-1:0]);

  assign fill.ready  = !full;
  assign drain.valid = !empty;
  assign drain.data  = s_ff.mem[s_ff.rd_ptr[AW-1:0]];

  always_comb
  begin
    nxt_s = s_ff;
    if (fill.valid && !full)
    begin
      nxt_s.mem[s_ff.wr_ptr[AW-1:0]] = fill.data;
      nxt_s.wr_ptr = s_ff.wr_ptr + 1'b1;
    end
    if (drain.ready && !empty)
    begin
      nxt_s.rd_ptr = s_ff.rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s_ff <= '0;
    end
    else if (ce)
    begin
      s_ff <= nxt_s;
    end
  end

endmodule // cra_fifo

`default_nettype wire

// [hdl/cra_pkg.sv]
// Types shared by the CRC accelerator modules.
package cra_pkg;

  // ****************************************
  // Engine states
  // ****************************************
  typedef enum logic [1:0] {
    CRA_IDLE = 2'b01,
    CRA_RUN  = 2'b10
  } cra_state_t;

  // ****************************************
  // Whole state of the accelerator except the input FIFO
  // ****************************************
  typedef struct packed {
    logic        halfword_swap;
    logic        byte_mirror;
    logic        bit_mirror;
    logic        reflected_order;
    logic        enable;
    logic [31:0] result;
    logic [31:0] divisor;
    logic [31:0] mirrored_input;
    logic [4:0]  bit_cnt;
    cra_state_t  state;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } cra_regs_t;

endpackage

// [hdl/cra_stream_if.sv]
// Valid/ready word stream between the accelerator and its input FIFO.
`timescale 1ns/1ns
`default_nettype none

interface cra_stream_if #(
  parameter int W = 32
);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;

  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

`default_nettype wire

// [verif/cra_accel_props.sv]
// Checker of the CRC accelerator's bus-visible behaviour.
`timescale 1ns/1ns
`default_nettype none
`include "cra_defs.svh"

module cra_accel_props #(
  parameter logic [3:0] REVISION = 4'h3
) (
  // Clock, reset and power
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        ce,
  input wire logic        hib_exit,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata
);
  // ****************************************
  // Shadows of software-visible state
  // ****************************************
  // Each word is credited one cycle less than the engine needs, so a correct answer never fires.
  logic [4:0]  ctl_ff;
  logic [31:0] div_ff;
  logic [11:0] work_ff;
  logic        mapped;
  logic        wr_in;
  assign mapped = paddr[31:4] == 28'h4004000 && paddr[1:0] == 2'h0;
  assign wr_in  = pready && pwrite && paddr == `CRA_ADDR_INPUT;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ctl_ff  <= 5'h00;
      div_ff  <= `CRA_DIVISOR_RST;
      work_ff <= 12'h000;
    end
    else if (ce)
    begin
      if (pready && pwrite && paddr == `CRA_ADDR_CTRL)
        ctl_ff <= pwdata[4:0];
      if (hib_exit)
        ctl_ff[0] <= 1'b0;
      if (pready && pwrite && paddr == `CRA_ADDR_DIVISOR)
        div_ff <= pwdata;
      work_ff <= work_ff + ((wr_in && ctl_ff[0]) ? 12'h020 : 12'h000)
                 - ((work_ff != 12'h000) ? 12'h001 : 12'h000);
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_rd(logic [31:0] a);
    pready && !pwrite && paddr == a;
  endsequence

  a_ready_in_access:
    assert property (pready |-> psel && penable) else $error("ready outside access");
  a_ready_one_cycle:
    assert property (pready |=> !pready) else $error("ready longer than one cycle");
  a_ctrl_readback:
    assert property (s_rd(`CRA_ADDR_CTRL) |-> prdata == {REVISION, 23'h000000, ctl_ff})
      else $error("control readback wrong");
  a_input_reads_zero:
    assert property (s_rd(`CRA_ADDR_INPUT) |-> prdata == 32'h0000_0000)
      else $error("input word readable");
  a_divisor_readback:
    assert property (s_rd(`CRA_ADDR_DIVISOR) |-> prdata == div_ff)
      else $error("divisor readback wrong");
  a_engine_first:
    assert property (pready && !(wr_in && ctl_ff[0]) |-> work_ff == 12'h000)
      else $error("access done before engine idle");
  a_error_unmapped:
    assert property (pready || pslverr |-> pready && (pslverr == !mapped))
      else $error("error response wrong");
  a_prdata_holds:
    assert property (!pready |-> $stable(prdata)) else $error("read data moved");
  a_freeze_outputs:
    assert property (!ce |=> $stable(pready) && $stable(pslverr) && $stable(prdata))
      else $error("outputs moved while frozen");
endmodule // cra_accel_props

`default_nettype wire

// [verif/cra_accel_tb.sv]
// Self-checking testbench of the CRC accelerator.
`timescale 1ns/1ns
`default_nettype none
`include "cra_defs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end

module cra_accel_tb;
  localparam logic [3:0] REV = 4'h5; // Arbitrary value.
  logic        clk, reset, ce, hib_exit, psel, penable, pwrite, pready, pslverr, err;
  logic [31:0] paddr, pwdata, prdata, rd, crc_reduction_divisor, seed, exp_r;
  logic [4:0]  m;
  int          n_errors = 0;
  int          compares = 0;
  int          cyc = 0;
  int          c0;
  int          seed_v;

  cra_accel #(.REVISION(REV), .DEPTH(`CRA_FIFO_DEPTH)) cra_accel_i (.clk, .reset, .ce,
    .hib_exit, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata);

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ****************************************
  // Bus master and reference model
  // ****************************************
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] mir(logic [31:0] d, logic [4:0] c);
    logic [31:0] t;
    if (c[4]) d = {d[15:0], d[31:16]};
    if (c[3]) d = {d[23:16], d[31:24], d[7:0], d[15:8]};
    for (int i = 0; i < 32; i++) t[i] = c[2] ? d[i - i % 8 + 7 - i % 8] : d[i];
    return t;
  endfunction

  function automatic logic [31:0] fold(logic [31:0] c, logic [31:0] w, logic [4:0] k);
    logic [31:0] d;
    d = mir(w, k);
    for (int i = 31; i >= 0; i--)
      if (k[1]) c = (c >> 1) ^ ((c[0] ^ d[i]) ? crc_reduction_divisor : 32'h0000_0000);
      else c = (c << 1) ^ ((c[31] ^ d[i]) ? crc_reduction_divisor : 32'h0000_0000);
    return c;
  endfunction

  task automatic put(input logic [31:0] w);
    bus(1'b1, `CRA_ADDR_INPUT, w);
    if (m[0]) exp_r = fold(exp_r, w, m);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {reset, ce, hib_exit, psel, penable, pwrite} = 6'h30;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    seed_v = 4;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    bus(1'b0, `CRA_ADDR_CTRL, 32'h0); `CHK(rd, {REV, 28'h0})
    bus(1'b0, `CRA_ADDR_RESULT, 32'h0); `CHK(rd, `CRA_ZERO_RST)
    bus(1'b0, `CRA_ADDR_DIVISOR, 32'h0); `CHK(rd, `CRA_DIVISOR_RST)
    bus(1'b0, 32'h4004_0010, 32'h0); `CHK({err, rd}, 33'h1_0000_0000)
    $display("test reset done");
    for (int k = 0; k < 16; k++)
    begin
      crc_reduction_divisor = $random(seed_v);
      seed = $random(seed_v);
      m = {k[3:0], 1'b1};
      bus(1'b1, `CRA_ADDR_DIVISOR, crc_reduction_divisor);
      bus(1'b1, `CRA_ADDR_RESULT, seed);
      bus(1'b1, `CRA_ADDR_CTRL, ($random(seed_v) & 32'hffff_ffe0) | m);
      exp_r = seed;
      bus(1'b0, `CRA_ADDR_CTRL, 32'h0); `CHK(rd, {REV, 23'h0, m})
      repeat (k == 15 ? 40 : 2) put($random(seed_v));
      bus(1'b0, `CRA_ADDR_RESULT, 32'h0); `CHK(rd, exp_r)
      bus(1'b0, `CRA_ADDR_DIVISOR, 32'h0); `CHK(rd, crc_reduction_divisor)
    end
    bus(1'b0, `CRA_ADDR_INPUT, 32'h0); `CHK(rd, 32'h0)
    $display("test modes done");
    m = 5'h1b;
    bus(1'b1, `CRA_ADDR_CTRL, {27'h0, m});
    @(posedge clk);
    hib_exit <= 1'b1;
    @(posedge clk);
    hib_exit <= 1'b0;
    m[0] = 1'b0;
    bus(1'b0, `CRA_ADDR_CTRL, 32'h0); `CHK(rd, {REV, 23'h0, m})
    put($random(seed_v));
    bus(1'b0, `CRA_ADDR_RESULT, 32'h0); `CHK(rd, exp_r)
    bus(1'b0, `CRA_ADDR_DIVISOR, 32'h0); `CHK(rd, crc_reduction_divisor)
    $display("test hibernate done");
    m = 5'h07;
    bus(1'b1, `CRA_ADDR_CTRL, {27'h0, m});
    repeat (2) put($random(seed_v));
    ce <= 1'b0;
    c0 = cyc;
    fork
      begin
        repeat (100) @(posedge clk);
        ce <= 1'b1;
      end
      bus(1'b0, `CRA_ADDR_RESULT, 32'h0);
    join
    `CHK(rd, exp_r)
    `CHK(cyc - c0 > 100, 1'b1)
    $display("test freeze done");
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    bus(1'b0, `CRA_ADDR_DIVISOR, 32'h0); `CHK(rd, `CRA_DIVISOR_RST)
    bus(1'b0, `CRA_ADDR_CTRL, 32'h0); `CHK(rd, {REV, 28'h0})
    bus(1'b0, `CRA_ADDR_RESULT, 32'h0); `CHK(rd, `CRA_ZERO_RST)
    $display("test second reset done");
    wrap_up();
  end
endmodule // cra_accel_tb

bind cra_accel cra_accel_props #(.REVISION(REVISION)) cra_accel_props_i (.clk, .reset,
  .ce, .hib_exit, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata);

`default_nettype wire
